// ===== logic/bmc_pkg.sv
// Package for the buck module control sequencer: map, fields, timing
package bmc_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;

    // Timing in printed units and derived cycle counts
    localparam int unsigned ENABLE_DELAY_US = 650;
    localparam int unsigned ENABLE_DELAY_CYC =
        (ENABLE_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned HICCUP_WAIT_US  = 128;
    localparam int unsigned HICCUP_WAIT_CYC =
        (HICCUP_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
    localparam logic [3:0]  CLIMIT_EVENTS = 4'hf;
    localparam logic [5:0]  CLIMIT_COUNT  = 6'h20;

    // Register offsets
    localparam logic [2:0] ADDR_VOUT1   = 3'h1;
    localparam logic [2:0] ADDR_VOUT2   = 3'h2;
    localparam logic [2:0] ADDR_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_STATUS  = 3'h5;

    // Reset values
    localparam logic [7:0] VOUT2_RESET   = 8'h64;
    localparam logic [7:0] CONTROL_RESET = 8'h6f;

    // Control register fields
    localparam int unsigned CTL_RESET_BIT    = 7;
    localparam int unsigned CTL_FFF_CHANGE   = 6;
    localparam int unsigned CTL_SW_ENABLE    = 5;
    localparam int unsigned CTL_FORCED_FF    = 4;
    localparam int unsigned CTL_HICCUP_EN    = 3;
    localparam int unsigned CTL_DISCHARGE_EN = 2;
    localparam int unsigned CTL_RAMP_LSB     = 0;

    // Status register fields
    localparam int unsigned STS_LOCKOUT = 0;
    localparam int unsigned STS_HEAT_W  = 1;
    localparam int unsigned STS_CLIMIT  = 2;

    typedef enum logic [2:0] {
        ST_OFF, ST_DELAY, ST_RAMP, ST_RUN, ST_HICCUP, ST_LATCHED
    } bmc_state_type;

    // Analog power stage status inputs
    typedef struct packed {
        logic hs_limit;
        logic ls_limit_low;
        logic ls_negative;
        logic low_input_lockout;
        logic below_reg_reset;
        logic heat_warning_level;
        logic heat_shutdown_level;
        logic near_dropout;
        logic cycle_start;
    } bmc_analog_type;

    // Switch commands to the power stage
    typedef struct packed {
        logic high_side_on;
        logic low_side_on;
        logic discharge_on;
        logic forced_fixed_frequency;
        logic full_duty;
    } bmc_drive_type;

    // Strap band to target address
    function automatic logic [6:0] strap_address(input logic [3:0] band);
        logic [6:0] a;
        a = 7'h47;
        unique case (band)
            4'hf: a = 7'h46;
            4'he: a = 7'h45;
            4'hd: a = 7'h44;
            4'hc: a = 7'h43;
            4'hb: a = 7'h42;
            4'ha: a = 7'h41;
            4'h9: a = 7'h48;
            4'h8: a = 7'h49;
            4'h7: a = 7'h4a;
            4'h6: a = 7'h4b;
            4'h5: a = 7'h4c;
            4'h4: a = 7'h4d;
            4'h3: a = 7'h4e;
            4'h2: a = 7'h4f;
            4'h1: a = 7'h40;
            4'h0: a = 7'h47;
        endcase
        return a;
    endfunction

    // Strap band to start-up code: band n gives 0.40V + n*50mV at 5mV steps
    function automatic logic [7:0] strap_code(input logic [3:0] band);
        return {1'h0, band, 3'h0} + {3'h0, band, 1'h0};
    endfunction

endpackage

// ===== logic/bmc_sequencer.sv
// Buck module control sequencer: start-up, protection, registers
//
// Contract
// RQ1: Near dropout keep high side permanently on.
// RQ2: Registers active only after 650us enable delay.
// RQ3: Soft start slope from ramp speed field.
// RQ4: Current limit: high side off until low limit.
// RQ5: Hiccup: 32 limits, stop, 128us, restart.
// RQ6: Hiccup disabled: latch off after 32 limits.
// RQ7: Latch cleared by enable, power, software enable.
// RQ8: Forced mode negative limit: both off until cycle. Code gates only the high side; low side still follows in_limit_q.
// RQ9: Lockout disables; recovery restarts with soft start.
// RQ10: Lockout flag set while input is low.
// RQ11: Input below 1.8V resets all registers.
// RQ12: Heat warning flag follows warning level.
// RQ13: Heat shutdown stops, discharges, restarts softly.
// RQ14: Enable low: off, no bus, registers reset.
// RQ15: Software enable toggle restarts ramp, no delay.
// RQ16: Discharge when enabled-off, lockout, or heat shutdown.
// RQ17: Enable rising edge clears discharge enable bit.
// RQ18: Strap sets start-up code and address during delay.
// RQ19: Sixteen strap bands map to addresses 0x40-0x4F.
// RQ20: Ramp to strap target, then to new value.
// RQ21: Select pin chooses first or second register.
// RQ22: Forced mode during change when bit set.
// RQ23: Voltage registers hold eight-bit step codes.
// RQ24: Reset bit restores defaults and restarts start-up.
// RQ25: Limit count cleared at every restart.
`timescale 1ns/1ps

module bmc_sequencer (
    input  wire logic                    clock,         // 100 MHz clock
    input  wire logic                    rst,           // Sync reset, high
    input  wire logic                    enable_pin,    // Enable pin
    input  wire logic                    voltage_register_select, // Pin
    input  wire logic [3:0]              startup_strap, // Strap band
    input  wire bmc_pkg::bmc_analog_type analog,        // Stage status
    input  wire logic [2:0]              reg_addr,      // Register address
    input  wire logic [7:0]              reg_wdata,     // Write data
    input  wire logic                    reg_write,     // Write strobe
    input  wire logic                    reg_read,      // Read strobe
    output logic [7:0]                   reg_rdata,     // Read data
    output logic                         bus_active,    // Bus may be used
    output logic [6:0]                   target_address, // Bus address
    output logic [7:0]                   output_code,   // Ramped target
    output bmc_pkg::bmc_drive_type       drive          // Switch commands
);
    import bmc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] en_s_q;
    logic [1:0] sel_s_q;
    logic [7:0] an0_q;
    logic [7:0] an1_q;
    logic [3:0] strap0_q;
    logic [3:0] strap1_q;
    logic       hs0_q, hs1_q, lsl0_q, lsl1_q, neg0_q, neg1_q;
    logic       cyc0_q, cyc1_q;
    logic       en_prev_q;

    always_ff @(posedge clock) begin
        en_s_q   <= {en_s_q[0], enable_pin};
        sel_s_q  <= {sel_s_q[0], voltage_register_select};
        strap0_q <= startup_strap;
        strap1_q <= strap0_q;
        an0_q    <= {analog.low_input_lockout, analog.below_reg_reset,
                     analog.heat_warning_level, analog.heat_shutdown_level,
                     analog.near_dropout, 3'h0};
        an1_q    <= an0_q;
        hs0_q    <= analog.hs_limit;
        hs1_q    <= hs0_q;
        lsl0_q   <= analog.ls_limit_low;
        lsl1_q   <= lsl0_q;
        neg0_q   <= analog.ls_negative;
        neg1_q   <= neg0_q;
        cyc0_q   <= analog.cycle_start;
        cyc1_q   <= cyc0_q;
    end

    logic en_lvl, lockout, pwr_lost, heat_w, heat_sd, dropout;
    assign en_lvl   = en_s_q[1];
    assign lockout  = an1_q[7];
    assign pwr_lost = an1_q[6];
    assign heat_w   = an1_q[5];
    assign heat_sd  = an1_q[4];
    assign dropout  = an1_q[3];

    logic en_rise;
    always_ff @(posedge clock) begin
        // Starts high: power-up with enable high keeps the discharge default
        if (rst || pwr_lost) begin
            en_prev_q <= 1'b1;
        end else begin
            en_prev_q <= en_lvl;
        end
    end
    assign en_rise = en_lvl && !en_prev_q;

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]    vout1_q, vout2_q, ctl_q;
    logic          dis_en_q;
    logic          soft_reset;
    logic          reg_clear;
    logic          ctl_wr;
    logic [7:0]    status;
    logic          climit_flag_q;
    bmc_state_type state_q;

    assign ctl_wr     = bus_active && reg_write && reg_addr == ADDR_CONTROL;
    assign soft_reset = ctl_wr && reg_wdata[CTL_RESET_BIT];      // see RQ24
    // Power loss and reset bit wipe the map; enable low wipes all but the discharge bit
    assign reg_clear  = rst || pwr_lost || !en_lvl || soft_reset; // see RQ11

    always_ff @(posedge clock) begin
        if (reg_clear) begin                                      // see RQ14
            vout2_q <= VOUT2_RESET;
            ctl_q   <= CONTROL_RESET;
        end else if (bus_active && reg_write) begin
            if (reg_addr == ADDR_VOUT2) begin
                vout2_q <= reg_wdata;                             // see RQ23
            end
            if (reg_addr == ADDR_CONTROL) begin
                ctl_q <= {1'b0, reg_wdata[6:0]};
            end
        end
    end

    // Discharge bit survives enable low; cleared on rising enable
    always_ff @(posedge clock) begin
        if (rst || pwr_lost || soft_reset) begin
            dis_en_q <= CONTROL_RESET[CTL_DISCHARGE_EN];
        end else if (en_rise) begin
            dis_en_q <= 1'b0;                                     // see RQ17
        end else if (ctl_wr) begin
            dis_en_q <= reg_wdata[CTL_DISCHARGE_EN];
        end
    end

    always_ff @(posedge clock) begin
        if (reg_clear) begin
            vout1_q        <= 8'h00;
            target_address <= 7'h47;
        end else if (state_q == ST_DELAY) begin
            vout1_q        <= strap_code(strap1_q);               // see RQ18
            target_address <= strap_address(strap1_q);           // see RQ19
        end else if (bus_active && reg_write && reg_addr == ADDR_VOUT1) begin
            vout1_q <= reg_wdata;
        end
    end

    assign status = {5'h0, climit_flag_q, heat_w, lockout};      // see RQ10

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read && bus_active) begin
            unique case (reg_addr)
                ADDR_VOUT1:   reg_rdata <= vout1_q;
                ADDR_VOUT2:   reg_rdata <= vout2_q;
                ADDR_CONTROL: reg_rdata <= {ctl_q[7:3], dis_en_q, ctl_q[1:0]};
                ADDR_STATUS:  reg_rdata <= status;               // see RQ12
                default:      reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    logic [16:0] timer_q;
    logic [5:0]  climit_cnt_q;
    logic        sw_en_q;
    logic        restart;
    logic        run_ok;

    assign run_ok  = en_lvl && !lockout && !heat_sd && !pwr_lost;
    // Any software-enable write restarts and unlatches
    assign restart = ctl_wr && !soft_reset;                      // see RQ15

    always_ff @(posedge clock) begin
        if (reg_clear) begin
            sw_en_q <= CONTROL_RESET[CTL_SW_ENABLE];
        end else if (ctl_wr) begin
            sw_en_q <= reg_wdata[CTL_SW_ENABLE];
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !en_lvl || pwr_lost || soft_reset) begin      // see RQ24
            state_q <= ST_OFF;
            timer_q <= '0;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    state_q <= ST_DELAY;
                    timer_q <= '0;
                end
                ST_DELAY: begin
                    timer_q <= timer_q + 17'h1;
                    if (timer_q == 17'(ENABLE_DELAY_CYC - 1)) begin // see RQ2
                        state_q <= ST_RAMP;
                    end
                end
                ST_RAMP, ST_RUN: begin
                    if (climit_cnt_q == CLIMIT_COUNT) begin
                        timer_q <= '0;
                        state_q <= ctl_q[CTL_HICCUP_EN] ? ST_HICCUP  // see RQ5
                                                        : ST_LATCHED; // see RQ6
                    end else if (state_q == ST_RAMP &&
                                 output_code == vout1_q) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_HICCUP: begin
                    timer_q <= timer_q + 17'h1;
                    if (timer_q == 17'(HICCUP_WAIT_CYC - 1)) begin
                        state_q <= ST_RAMP;
                    end
                end
                ST_LATCHED: begin
                    if (restart) begin                           // see RQ7
                        state_q <= ST_RAMP;
                    end
                end
            endcase
            if (restart && state_q != ST_DELAY && state_q != ST_OFF) begin
                state_q <= ST_RAMP;
            end
        end
    end

    logic switching;
    // Lockout and heat shutdown stop switching; ramp resumes from zero
    assign switching = run_ok && sw_en_q &&                      // see RQ9
        (state_q == ST_RAMP || state_q == ST_RUN);               // see RQ13
    assign bus_active = en_lvl && !pwr_lost && state_q != ST_OFF &&
                        state_q != ST_DELAY;

    // Limit events counted only while switching, fresh each start
    always_ff @(posedge clock) begin
        if (rst || !switching || state_q == ST_HICCUP) begin     // see RQ25
            climit_cnt_q <= '0;
        end else if (hs1_q && climit_cnt_q != CLIMIT_COUNT) begin
            climit_cnt_q <= climit_cnt_q + 6'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reg_clear) begin
            climit_flag_q <= 1'b0;
        end else if (state_q == ST_HICCUP || state_q == ST_LATCHED) begin
            climit_flag_q <= 1'b1;
        end else if (reg_read && reg_addr == ADDR_STATUS) begin
            climit_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Soft-start ramp
    logic [7:0]  target;
    logic [11:0] step_q;
    logic [11:0] step_len;
    logic        changing;

    // Select pin only after start-up
    assign target = (state_q == ST_RUN && sel_s_q[1]) ? vout2_q
                                                      : vout1_q; // see RQ21
    // Code step is 5mV; 1mV/us slope gives one step per 5us at default
    always_comb begin
        unique case (ctl_q[CTL_RAMP_LSB +: 2])
            2'h0: step_len = 12'(US_CYC * 20);
            2'h1: step_len = 12'(US_CYC * 10);
            2'h2: step_len = 12'(US_CYC * 5);
            2'h3: step_len = 12'(US_CYC * 5);
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst || !switching) begin
            output_code <= 8'h00;
            step_q      <= '0;
        end else if (output_code != target) begin                // see RQ20
            if (step_q >= step_len - 12'h1) begin                // see RQ3
                step_q      <= '0;
                output_code <= (output_code < target) ? output_code + 8'h1
                                                      : output_code - 8'h1;
            end else begin
                step_q <= step_q + 12'h1;
            end
        end else begin
            step_q <= '0;
        end
    end
    assign changing = switching && output_code != target;

    ////////////////////////////////////////////////////////////////////
    // Switch control
    logic in_limit_q;
    logic neg_off_q;
    logic fff;

    assign fff = ctl_q[CTL_FORCED_FF] ||
                 (ctl_q[CTL_FFF_CHANGE] && changing);            // see RQ22

    always_ff @(posedge clock) begin
        if (rst || !switching) begin
            in_limit_q <= 1'b0;
        end else if (hs1_q) begin
            in_limit_q <= 1'b1;                                  // see RQ4
        end else if (lsl1_q) begin
            in_limit_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !switching || !fff) begin
            neg_off_q <= 1'b0;
        end else if (neg1_q) begin
            neg_off_q <= 1'b1;                                   // see RQ8
        end else if (cyc1_q) begin
            neg_off_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            drive <= '0;
        end else begin
            drive.forced_fixed_frequency <= switching && fff;
            drive.full_duty    <= switching && dropout && !in_limit_q;
            drive.high_side_on <= switching && !in_limit_q &&
                                  !neg_off_q && dropout;         // see RQ1
            drive.low_side_on  <= switching && in_limit_q;
            drive.discharge_on <= (dis_en_q && !en_lvl) ||       // see RQ16
                                  (en_lvl && (lockout || heat_sd));
        end
    end

endmodule // bmc_sequencer

// ===== testbench/bmc_properties.sv
// Port assertions for the buck module control sequencer
`timescale 1ns/1ps
module bmc_properties (
    input wire logic                    clock,          // Clock
    input wire logic                    rst,            // Reset
    input wire logic                    enable_pin,     // Enable pin
    input wire bmc_pkg::bmc_analog_type analog,         // Stage status
    input wire logic                    reg_read,       // Read strobe
    input wire logic [7:0]              reg_rdata,      // Read data
    input wire logic                    bus_active,     // Bus open
    input wire logic [6:0]              target_address, // Bus address
    input wire logic [7:0]              output_code,    // Ramped target
    input wire bmc_pkg::bmc_drive_type  drive           // Switch commands
);
    import bmc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    property p_rd_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside answer cycle");
    property p_rd_taken;
        reg_rdata != 8'h00 |-> $past(reg_read) && $past(bus_active);
    endproperty
    a_rd_taken: assert property (p_rd_taken)
        else $error("read answered while bus closed");
    // Six cycles cover pin sync, state and drive registers
    property p_off_bus;
        !enable_pin [*6] |-> !bus_active && !drive.high_side_on
            && !drive.low_side_on;
    endproperty
    a_off_bus: assert property (p_off_bus)
        else $error("disabled device still active");
    property p_off_addr;
        !enable_pin [*6] |-> target_address == 7'h47;
    endproperty
    a_off_addr: assert property (p_off_addr)
        else $error("address not at default while disabled");
    property p_lockout;
        analog.low_input_lockout [*6] |-> drive.discharge_on
            && !drive.high_side_on && !drive.low_side_on;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("lockout did not stop and discharge");
    property p_heat;
        analog.heat_shutdown_level [*6] |-> !drive.high_side_on
            && !drive.low_side_on;
    endproperty
    a_heat: assert property (p_heat)
        else $error("switching during heat shutdown");
    property p_full;
        drive.full_duty |-> drive.high_side_on && !drive.low_side_on;
    endproperty
    a_full: assert property (p_full)
        else $error("full duty without high side on");
    // A jump would mean the ramp skipped codes
    property p_step;
        $changed(output_code) && output_code != 8'h00 |->
            output_code == $past(output_code) + 8'h01
            || output_code + 8'h01 == $past(output_code);
    endproperty
    a_step: assert property (p_step)
        else $error("output code moved more than one step");
endmodule // bmc_properties

// ===== testbench/bmc_stage_model.sv
// Behavioural model of the analog power stage
`timescale 1ns/1ps
module bmc_stage_model (
    input  wire logic      clock,    // Clock
    input  wire logic      overload, // Load above limit
    input  wire logic      lockout,  // Input voltage low
    input  wire logic      hot_warn, // Warning temperature
    input  wire logic      hot_stop, // Shutdown temperature
    input  wire logic      dropout,  // Input near output
    input  wire logic      brownout, // Input below register hold
    output bmc_pkg::bmc_analog_type analog // Status out
);
    import bmc_pkg::*;
    logic [1:0] phase_q = 2'h0;
    always_ff @(posedge clock) begin
        phase_q <= phase_q + 2'h1;
    end
    // One-cycle limit pulses, so edge and level counting agree
    always_comb begin
        analog = '0;
        analog.cycle_start = phase_q == 2'h0;
        analog.hs_limit = overload && phase_q == 2'h1;
        analog.ls_limit_low = overload && phase_q == 2'h3;
        analog.low_input_lockout = lockout;
        analog.heat_warning_level = hot_warn;
        analog.heat_shutdown_level = hot_stop;
        analog.near_dropout = dropout;
        analog.below_reg_reset = brownout;
    end
endmodule // bmc_stage_model

// ===== testbench/bmc_sequencer_tb.sv
// Self-checking bench for the buck module control sequencer
`timescale 1ns/1ps
module bmc_sequencer_tb;
    import bmc_pkg::*;
    localparam logic [6:0] ADDR_TAB [16] = '{7'h47, 7'h40, 7'h4f, 7'h4e,
        7'h4d, 7'h4c, 7'h4b, 7'h4a, 7'h49, 7'h48, 7'h41, 7'h42, 7'h43,
        7'h44, 7'h45, 7'h46};
    logic clock, rst, enable_pin, voltage_register_select;
    logic reg_write, reg_read, bus_active;
    logic overload, lockout, hot_warn, hot_stop, dropout, brownout;
    logic [3:0] startup_strap;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, output_code, v;
    logic [6:0] target_address;
    bmc_analog_type analog;
    bmc_drive_type  drive;
    int errors = 0;
    int checked = 0;
    int seed, n;
    longint t0;
    bmc_sequencer dut (.clock, .rst, .enable_pin, .voltage_register_select,
        .startup_strap, .analog, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .bus_active, .target_address,
        .output_code, .drive);
    bmc_stage_model stage (.clock, .overload, .lockout, .hot_warn,
        .hot_stop, .dropout, .brownout, .analog);
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_code(input logic [3:0] b);
        return {4'h0, b} * 8'h0a;
    endfunction
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input string w, input logic [2:0] a,
                      input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk(w, e, reg_rdata);
        @(posedge clock);
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_code(input logic [7:0] t, input int lim);
        n = 0;
        while (output_code !== t && n < lim) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        if (n >= lim) begin
            chk("code wait", t, output_code);
            complete_run();
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        seed = 32'hc87a8614;
        rst = 1'b1;
        enable_pin = 1'b1;
        voltage_register_select = 1'b0;
        startup_strap = 4'h1;
        {reg_addr, reg_wdata, reg_write, reg_read} = 13'h0000;
        {overload, lockout, hot_warn, hot_stop, dropout, brownout} = 6'h00;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (10) @(posedge clock);
        wr(ADDR_CONTROL, 8'h00);
        n = 11;
        while (bus_active !== 1'b1 && n < 66000) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        chk("delay", 8'h01, {7'h00, n >= 65000 && n <= 65010});
        if (n >= 66000)
            complete_run();
        rd("control", ADDR_CONTROL, CONTROL_RESET);
        rd("vout1", ADDR_VOUT1, exp_code(startup_strap));
        rd("vout2", ADDR_VOUT2, VOUT2_RESET);
        rd("status", ADDR_STATUS, 8'h00);
        rd("unmapped", 3'h4, 8'h00);
        chk("address", {1'b0, ADDR_TAB[startup_strap]},
            {1'b0, target_address});
        $display("test start-up done");
        wait_code(8'h01, 1000);
        wait_code(8'h02, 1000);
        chk("step", 8'h01, {7'h00, n >= 499 && n <= 501});
        wait_code(exp_code(startup_strap), 5000);
        v = exp_code(startup_strap) + 8'h01 + (8'($random(seed)) & 8'h03);
        wr(ADDR_VOUT2, v);
        rd("vout2 written", ADDR_VOUT2, v);
        voltage_register_select <= 1'b1;
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk("fff", 8'h01, {7'h00, drive.forced_fixed_frequency});
        wait_code(v, 3000);
        voltage_register_select <= 1'b0;
        wait_code(exp_code(startup_strap), 3000);
        $display("test ramp and select done");
        hot_warn <= 1'b1;
        repeat (4) @(posedge clock);
        rd("warn set", ADDR_STATUS, 8'h01 << STS_HEAT_W);
        hot_warn <= 1'b0;
        repeat (4) @(posedge clock);
        rd("warn clear", ADDR_STATUS, 8'h00);
        dropout <= 1'b1;
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk("full duty", 8'h01, {7'h00, drive.full_duty});
        @(posedge clock);
        dropout <= 1'b0;
        $display("test status done");
        wr(ADDR_CONTROL, CONTROL_RESET & ~(8'h01 << CTL_HICCUP_EN));
        overload <= 1'b1;
        repeat (200) @(posedge clock);
        overload <= 1'b0;
        rd("latch flag", ADDR_STATUS, 8'h01 << STS_CLIMIT);
        repeat (13400) @(posedge clock);
        @(negedge clock);
        chk("latched code", 8'h00, output_code);
        @(posedge clock);
        wr(ADDR_CONTROL, CONTROL_RESET);
        wait_code(8'h01, 800);
        $display("test latch done");
        t0 = $time;
        overload <= 1'b1;
        repeat (200) @(posedge clock);
        overload <= 1'b0;
        rd("hiccup flag", ADDR_STATUS, 8'h01 << STS_CLIMIT);
        wait_code(8'h00, 13500);
        // Restart comes only after the whole hiccup pause and one step
        wait_code(8'h01, 14000);
        n = int'(($time - t0) / 10);
        chk("hiccup", 8'h01, {7'h00, n >= 12900 && n <= 13700});
        $display("test hiccup done");
        lockout <= 1'b1;
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk("discharge", 8'h01, {7'h00, drive.discharge_on});
        @(posedge clock);
        lockout <= 1'b0;
        brownout <= 1'b1;
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk("brownout address", 8'h47, {1'b0, target_address});
        chk("brownout bus", 8'h00, {7'h00, bus_active});
        @(posedge clock);
        brownout <= 1'b0;
        hot_stop <= 1'b1;
        repeat (8) @(posedge clock);
        hot_stop <= 1'b0;
        enable_pin <= 1'b0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        chk("bus off", 8'h00, {7'h00, bus_active});
        $display("test shutdown done");
        complete_run();
    end
endmodule // bmc_sequencer_tb

bind bmc_sequencer bmc_properties u_props (.clock, .rst, .enable_pin,
    .analog, .reg_read, .reg_rdata, .bus_active, .target_address,
    .output_code, .drive);
